// File: rsq_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the sequencing registers
// Assumes: one 200 MHz clock
// Notes:   definitions only
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

`define RSQ_ADDR_W          6
`define RSQ_DATA_W          16
`define RSQ_OFF_TIMING      6'h20
`define RSQ_OFF_AND_MASK    6'h21
`define RSQ_OFF_OR_MASK     6'h22

`define RSQ_TIMING_RST      16'h7A94
`define RSQ_AND_MASK_RST    16'hFFFF
`define RSQ_OR_MASK_RST     16'h0000

// timing register fields
`define RSQ_F_RX_DEMOD      15:13
`define RSQ_F_SW_LEAD       12:10
`define RSQ_F_AMP_LEAD      9:6
`define RSQ_F_END_SW        5:3
`define RSQ_F_END_AMP       2:0

// control bit positions, shared by both masks
`define RSQ_B_VGA_RESET_N   15
`define RSQ_B_BIAS_DOWN     14
`define RSQ_B_SWITCH_BIAS   13
`define RSQ_B_PATH_SEL      12
`define RSQ_B_PRESCALER_PD  11
`define RSQ_B_AMP_NEG_PD    10
`define RSQ_B_AMP_POS_PD    9
`define RSQ_B_TX_CONV_PD    8
`define RSQ_B_XOSC_PD       7
`define RSQ_B_CAL_OSC_PD    6
`define RSQ_B_PUMP_PD       5
`define RSQ_B_SYNTH_PD      4
`define RSQ_B_RX_CONV_PD    3
`define RSQ_B_GAIN_AMP_PD   2
`define RSQ_B_RX_FILT_PD    1
`define RSQ_B_FRONT_END_PD  0

// generated control values while idle
`define RSQ_IDLE_CTRL       16'h4F7F

// timing
`define RSQ_CLK_PERIOD_NS   5
`define RSQ_US_NS           1000
`define RSQ_CYC_PER_US      ((`RSQ_US_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_RX_STEP_US      5
`define RSQ_SYMBOL_NS       16000
`define RSQ_CAL_HALF_SYMS   13
`define RSQ_CAL_CYCLES      ((`RSQ_CAL_HALF_SYMS * `RSQ_SYMBOL_NS / 2 + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)

`endif

// File: rsq_pkg.sv
// Purpose: types of the radio sequencing block
// Assumes: nothing
// Notes:   constants live in rsq_consts.svh
package rsq_pkg;

  typedef logic [15:0] rsq_word_t;

  // gray codes along rx path and from tx lead to tx tail; idle to tx lead and tx tail to idle change two bits
  typedef enum logic [2:0] {
    RSQ_IDLE      = 3'h0,
    RSQ_RX_CAL    = 3'h1,
    RSQ_RX_SETTLE = 3'h3,
    RSQ_RX_ON     = 3'h2,
    RSQ_TX_LEAD   = 3'h6,
    RSQ_TX_ON     = 3'h7,
    RSQ_TX_TAIL   = 3'h5
  } rsq_state_t;

endpackage

// File: rsq_us_tick.sv
// Purpose: microsecond tick that restarts on request
// Assumes: clr high in the cycle a timed phase begins
// Notes:   first tick comes one full microsecond after clr
`include "rsq_consts.svh"
module rsq_us_tick #(
  parameter int CYC_PER_US = `RSQ_CYC_PER_US
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clr,
  output logic      tick
);

  localparam int CW = $clog2(CYC_PER_US + 1);

  logic [CW-1:0] cnt;

  // restart keeps phase timing exact instead of up to 1 us early
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (clr)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt == CW'(CYC_PER_US - 1))
    begin
      cnt  <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule

// File: rsq_override.sv
// Purpose: per-bit and/or override of generated control signals
// Assumes: masks from the register bank, generated values on the same clock
// Notes:   one cycle from mask or value change to output
`include "rsq_consts.svh"
module rsq_override #(
  parameter int        W       = 16,
  parameter logic [15:0] RST_VAL = `RSQ_IDLE_CTRL
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] gen,
  input  wire logic [W-1:0] and_mask,
  input  wire logic [W-1:0] or_mask,
  output logic      [W-1:0] used
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          used[i] <= RST_VAL[i];
        else
          used[i] <= (gen[i] & and_mask[i]) | or_mask[i];
      end
    end
  endgenerate

endmodule

// File: rsq_seq_regs.sv
// Purpose: sequencing time constants and signal override masks of the radio control
// Assumes: config port and sequencing requests run on clk; analog controls are registered
// Notes:   config reads answer one cycle after cfg_rd_en; unmapped addresses read zero
`include "rsq_consts.svh"
module rsq_seq_regs #(
  parameter int CAL_CYCLES = `RSQ_CAL_CYCLES,
  parameter int CYC_PER_US = `RSQ_CYC_PER_US
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [`RSQ_ADDR_W-1:0]  cfg_addr,
  input  wire logic                    cfg_wr_en,
  input  wire logic [`RSQ_DATA_W-1:0]  cfg_wdata,
  input  wire logic                    cfg_rd_en,
  output logic      [`RSQ_DATA_W-1:0]  cfg_rdata,
  output logic                         cfg_rvalid,
  input  wire logic                    rx_request,
  input  wire logic                    tx_request,
  input  wire logic                    tx_last_chip,
  output logic                         rx_chain_enable,
  output logic                         demod_agc_enable,
  output logic                         tx_enable,
  output logic                         modulator_enable,
  output logic                         seq_busy,
  output logic                         vga_peak_reset_n,
  output logic                         global_bias_powerdown,
  output logic                         output_switch_bias_ctrl,
  output logic                         buffer_path_select,
  output logic                         prescaler_powerdown,
  output logic                         amp_neg_powerdown,
  output logic                         amp_pos_powerdown,
  output logic                         upmixer_powerdown,
  output logic                         tx_converter_powerdown,
  output logic                         crystal_osc_powerdown,
  output logic                         filter_cal_osc_powerdown,
  output logic                         charge_pump_powerdown,
  output logic                         synth_powerdown,
  output logic                         rx_converter_powerdown,
  output logic                         gain_amp_powerdown,
  output logic                         rx_filter_powerdown,
  output logic                         front_end_powerdown
);

  localparam int CALW = $clog2(CAL_CYCLES + 1);

  rsq_pkg::rsq_word_t    sequencer_time_constants;
  rsq_pkg::rsq_word_t    signal_override_and_mask;
  rsq_pkg::rsq_word_t    signal_override_or_mask;
  rsq_pkg::rsq_word_t    gen_ctrl;
  rsq_pkg::rsq_word_t    used_ctrl;
  rsq_pkg::rsq_state_t   state;
  rsq_pkg::rsq_state_t   next_state;
  logic                  state_change;
  logic                  us_tick;
  logic [5:0]            us_cnt;
  logic [CALW-1:0]       cal_cnt;
  logic [5:0]            rx_demod_delay;
  logic [3:0]            tx_lead;
  logic [3:0]            sw_start;
  logic [3:0]            amp_start;
  logic [2:0]            tail_len;
  logic                  switch_on;
  logic                  amp_on;

  function automatic logic reg_hit(input logic [`RSQ_ADDR_W-1:0] addr,
                                   input logic [`RSQ_ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic rx_chain_active(input rsq_pkg::rsq_state_t s);
    rx_chain_active = (s == rsq_pkg::RSQ_RX_SETTLE) || (s == rsq_pkg::RSQ_RX_ON);
  endfunction

  // register bank

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sequencer_time_constants <= `RSQ_TIMING_RST;
    else if (cfg_wr_en && reg_hit(cfg_addr, `RSQ_OFF_TIMING))
      sequencer_time_constants <= cfg_wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      signal_override_and_mask <= `RSQ_AND_MASK_RST;
    else if (cfg_wr_en && reg_hit(cfg_addr, `RSQ_OFF_AND_MASK))
      signal_override_and_mask <= cfg_wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      signal_override_or_mask <= `RSQ_OR_MASK_RST;
    else if (cfg_wr_en && reg_hit(cfg_addr, `RSQ_OFF_OR_MASK))
      signal_override_or_mask <= cfg_wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_rdata  <= '0;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd_en;
      if (cfg_rd_en)
      begin
        if (reg_hit(cfg_addr, `RSQ_OFF_TIMING))
          cfg_rdata <= sequencer_time_constants;
        else if (reg_hit(cfg_addr, `RSQ_OFF_AND_MASK))
          cfg_rdata <= signal_override_and_mask;
        else if (reg_hit(cfg_addr, `RSQ_OFF_OR_MASK))
          cfg_rdata <= signal_override_or_mask;
        else
          cfg_rdata <= '0;
      end
    end
  end

  // field decode; fields are read live so a rewrite steers the next phase
  // five microsecond steps
  assign rx_demod_delay = {3'h0, sequencer_time_constants[`RSQ_F_RX_DEMOD]} * 6'd5;
  assign sw_start  = (tx_lead - {1'b0, sequencer_time_constants[`RSQ_F_SW_LEAD]});
  assign amp_start = (tx_lead - sequencer_time_constants[`RSQ_F_AMP_LEAD]);

  always_comb
  begin
    // lead phase lasts as long as the longer of the two leads
    if ({1'b0, sequencer_time_constants[`RSQ_F_SW_LEAD]} >
        sequencer_time_constants[`RSQ_F_AMP_LEAD])
      tx_lead = {1'b0, sequencer_time_constants[`RSQ_F_SW_LEAD]};
    else
      tx_lead = sequencer_time_constants[`RSQ_F_AMP_LEAD];
    if (sequencer_time_constants[`RSQ_F_END_SW] > sequencer_time_constants[`RSQ_F_END_AMP])
      tail_len = sequencer_time_constants[`RSQ_F_END_SW];
    else
      tail_len = sequencer_time_constants[`RSQ_F_END_AMP];
  end

  // sequencer

  always_comb
  begin
    next_state = state;
    unique case (state)
      rsq_pkg::RSQ_IDLE:
      begin
        // transmit wins when both are requested
        if (tx_request)
          next_state = rsq_pkg::RSQ_TX_LEAD;
        else if (rx_request)
          next_state = rsq_pkg::RSQ_RX_CAL;
      end
      rsq_pkg::RSQ_RX_CAL:
      begin
        if (!rx_request)
          next_state = rsq_pkg::RSQ_IDLE;
        else if (cal_cnt == CALW'(CAL_CYCLES - 1))
          next_state = rsq_pkg::RSQ_RX_SETTLE;
      end
      rsq_pkg::RSQ_RX_SETTLE:
      begin
        if (!rx_request)
          next_state = rsq_pkg::RSQ_IDLE;
        else if (us_cnt >= rx_demod_delay)
          next_state = rsq_pkg::RSQ_RX_ON;
      end
      rsq_pkg::RSQ_RX_ON:
      begin
        if (tx_request)
          next_state = rsq_pkg::RSQ_TX_LEAD;
        else if (!rx_request)
          next_state = rsq_pkg::RSQ_IDLE;
      end
      rsq_pkg::RSQ_TX_LEAD:
      begin
        if (us_cnt >= {2'h0, tx_lead})
          next_state = rsq_pkg::RSQ_TX_ON;
      end
      rsq_pkg::RSQ_TX_ON:
      begin
        if (tx_last_chip)
          next_state = rsq_pkg::RSQ_TX_TAIL;
      end
      rsq_pkg::RSQ_TX_TAIL:
      begin
        if (us_cnt >= {3'h0, tail_len})
          next_state = rsq_pkg::RSQ_IDLE;
      end
      default:
        next_state = rsq_pkg::RSQ_IDLE;
    endcase
  end

  assign state_change = (next_state != state);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= rsq_pkg::RSQ_IDLE;
    else
      state <= next_state;
  end

  rsq_us_tick #(
    .CYC_PER_US (CYC_PER_US)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .clr    (state_change),
    .tick   (us_tick)
  );

  // microseconds spent in the current state; saturates
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      us_cnt <= '0;
    else if (state_change)
      us_cnt <= '0;
    else if (us_tick && us_cnt != 6'h3F)
      us_cnt <= us_cnt + 6'h01;
  end

  // calibration cycles, counted only while calibrating
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cal_cnt <= '0;
    else if (state_change || state != rsq_pkg::RSQ_RX_CAL)
      cal_cnt <= '0;
    else
      cal_cnt <= cal_cnt + CALW'(1);
  end

  always_comb
  begin
    switch_on = 1'b0;
    amp_on    = 1'b0;
    unique case (state)
      rsq_pkg::RSQ_TX_LEAD:
      begin
        switch_on = (us_cnt >= {2'h0, sw_start});
        amp_on    = (us_cnt >= {2'h0, amp_start});
      end
      rsq_pkg::RSQ_TX_ON:
      begin
        switch_on = 1'b1;
        amp_on    = 1'b1;
      end
      rsq_pkg::RSQ_TX_TAIL:
      begin
        switch_on = (us_cnt < {3'h0, sequencer_time_constants[`RSQ_F_END_SW]});
        amp_on    = (us_cnt < {3'h0, sequencer_time_constants[`RSQ_F_END_AMP]});
      end
      default:
        switch_on = 1'b0;
    endcase
  end

  // generated control values before override
  always_comb
  begin
    gen_ctrl = `RSQ_IDLE_CTRL;
    // peak detectors run only with demodulator
    gen_ctrl[`RSQ_B_VGA_RESET_N]  = (state == rsq_pkg::RSQ_RX_ON);
    gen_ctrl[`RSQ_B_BIAS_DOWN]    = (state == rsq_pkg::RSQ_IDLE);
    gen_ctrl[`RSQ_B_SWITCH_BIAS]  = switch_on;
    gen_ctrl[`RSQ_B_PATH_SEL]     = switch_on;
    gen_ctrl[`RSQ_B_PRESCALER_PD] = (state == rsq_pkg::RSQ_IDLE);
    gen_ctrl[`RSQ_B_TX_CONV_PD]   = !amp_on;
    gen_ctrl[`RSQ_B_CAL_OSC_PD]   = (state != rsq_pkg::RSQ_RX_CAL);
    gen_ctrl[`RSQ_B_AMP_NEG_PD]   = !amp_on;
    gen_ctrl[`RSQ_B_AMP_POS_PD]   = !amp_on;
    // crystal kept running; only an override stops it
    gen_ctrl[`RSQ_B_XOSC_PD]      = 1'b0;
    gen_ctrl[`RSQ_B_PUMP_PD]      = (state == rsq_pkg::RSQ_IDLE);
    gen_ctrl[`RSQ_B_SYNTH_PD]     = (state == rsq_pkg::RSQ_IDLE);
    gen_ctrl[`RSQ_B_RX_CONV_PD]   = !rx_chain_active(state);
    gen_ctrl[`RSQ_B_GAIN_AMP_PD]  = !rx_chain_active(state);
    gen_ctrl[`RSQ_B_RX_FILT_PD]   = !(rx_chain_active(state) || state == rsq_pkg::RSQ_RX_CAL);
    gen_ctrl[`RSQ_B_FRONT_END_PD] = !rx_chain_active(state);
  end

  // masks act the cycle after write
  rsq_override #(
    .W       (16),
    .RST_VAL (`RSQ_IDLE_CTRL)
  ) u_override (
    .clk      (clk),
    .resetn   (resetn),
    .gen      (gen_ctrl),
    .and_mask (signal_override_and_mask),
    .or_mask  (signal_override_or_mask),
    .used     (used_ctrl)
  );

  assign vga_peak_reset_n         = used_ctrl[`RSQ_B_VGA_RESET_N];
  assign global_bias_powerdown    = used_ctrl[`RSQ_B_BIAS_DOWN];
  assign output_switch_bias_ctrl  = used_ctrl[`RSQ_B_SWITCH_BIAS];
  assign buffer_path_select       = used_ctrl[`RSQ_B_PATH_SEL];
  assign prescaler_powerdown      = used_ctrl[`RSQ_B_PRESCALER_PD];
  assign amp_neg_powerdown        = used_ctrl[`RSQ_B_AMP_NEG_PD];
  assign amp_pos_powerdown        = used_ctrl[`RSQ_B_AMP_POS_PD];
  assign tx_converter_powerdown   = used_ctrl[`RSQ_B_TX_CONV_PD];
  assign crystal_osc_powerdown    = used_ctrl[`RSQ_B_XOSC_PD];
  assign filter_cal_osc_powerdown = used_ctrl[`RSQ_B_CAL_OSC_PD];
  assign charge_pump_powerdown    = used_ctrl[`RSQ_B_PUMP_PD];
  assign synth_powerdown          = used_ctrl[`RSQ_B_SYNTH_PD];
  assign rx_converter_powerdown   = used_ctrl[`RSQ_B_RX_CONV_PD];
  assign gain_amp_powerdown       = used_ctrl[`RSQ_B_GAIN_AMP_PD];
  assign rx_filter_powerdown      = used_ctrl[`RSQ_B_RX_FILT_PD];
  assign front_end_powerdown      = used_ctrl[`RSQ_B_FRONT_END_PD];

  // mixers follow the overridden halves, so same cycle as their inputs is kept
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      upmixer_powerdown <= 1'b1;
    else
      // mixers down when both halves down
      upmixer_powerdown <= (gen_ctrl[`RSQ_B_AMP_NEG_PD] & signal_override_and_mask[10]
                            | signal_override_or_mask[10])
                         & (gen_ctrl[`RSQ_B_AMP_POS_PD] & signal_override_and_mask[9]
                            | signal_override_or_mask[9]);
  end

  // enables follow the state itself; overrides act on the analog controls only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_chain_enable  <= 1'b0;
      demod_agc_enable <= 1'b0;
      tx_enable        <= 1'b0;
      modulator_enable <= 1'b0;
      seq_busy         <= 1'b0;
    end
    else
    begin
      rx_chain_enable  <= rx_chain_active(next_state);
      demod_agc_enable <= (next_state == rsq_pkg::RSQ_RX_ON);
      tx_enable        <= (next_state == rsq_pkg::RSQ_TX_ON);
      modulator_enable <= (state == rsq_pkg::RSQ_TX_ON) ||
                          (state == rsq_pkg::RSQ_TX_TAIL && amp_on &&
                           next_state == rsq_pkg::RSQ_TX_TAIL);
      seq_busy         <= (next_state != rsq_pkg::RSQ_IDLE);
    end
  end

endmodule

// File: rsq_seq_regs_props.sv
// Purpose: port checks of the sequencing register block
// Assumes: masks stay pass-through on sequencing controls during rx and tx runs
// Notes:   time windows allow a few cycles of register and override delay
`include "rsq_consts.svh"
module rsq_seq_regs_props #(
  parameter int CAL_CYCLES = `RSQ_CAL_CYCLES,
  parameter int CYC_PER_US = `RSQ_CYC_PER_US
) (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic [`RSQ_ADDR_W-1:0] cfg_addr,
  input wire logic [`RSQ_DATA_W-1:0] cfg_wdata,
  input wire logic                   cfg_wr_en, cfg_rd_en, cfg_rvalid, seq_busy,
  input wire logic                   rx_chain_enable, demod_agc_enable, tx_enable,
  input wire logic                   modulator_enable, upmixer_powerdown,
  input wire logic                   vga_peak_reset_n, global_bias_powerdown,
  input wire logic                   output_switch_bias_ctrl, buffer_path_select,
  input wire logic                   prescaler_powerdown, amp_neg_powerdown,
  input wire logic                   amp_pos_powerdown, tx_converter_powerdown,
  input wire logic                   crystal_osc_powerdown, filter_cal_osc_powerdown,
  input wire logic                   charge_pump_powerdown, synth_powerdown,
  input wire logic                   rx_converter_powerdown, gain_amp_powerdown,
  input wire logic                   rx_filter_powerdown, front_end_powerdown
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tim, am, om, ctrl, expw;
  int          cnt, on_cnt, n_demod, n_lead, n_sw, n_amp;

  assign ctrl = {vga_peak_reset_n, global_bias_powerdown, output_switch_bias_ctrl,
                 buffer_path_select, prescaler_powerdown, amp_neg_powerdown,
                 amp_pos_powerdown, tx_converter_powerdown, crystal_osc_powerdown,
                 filter_cal_osc_powerdown, charge_pump_powerdown, synth_powerdown,
                 rx_converter_powerdown, gain_amp_powerdown, rx_filter_powerdown,
                 front_end_powerdown};
  assign expw = (`RSQ_IDLE_CTRL & am) | om;

  // shadow copies of the three registers, fed from the config port
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      tim <= `RSQ_TIMING_RST;
      am  <= `RSQ_AND_MASK_RST;
      om  <= `RSQ_OR_MASK_RST;
    end
    else if (cfg_wr_en)
    begin
      if (cfg_addr == `RSQ_OFF_TIMING) tim <= cfg_wdata;
      if (cfg_addr == `RSQ_OFF_AND_MASK) am <= cfg_wdata;
      if (cfg_addr == `RSQ_OFF_OR_MASK) om <= cfg_wdata;
    end

  // cnt runs through calibration, tx lead and tx tail; on_cnt while the rx chain is on
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cnt <= 0;
    else if (!seq_busy || rx_chain_enable || tx_enable)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      on_cnt <= 0;
    else
      on_cnt <= rx_chain_enable ? on_cnt + 1 : 0;

  always_comb
  begin
    n_demod = int'(tim[`RSQ_F_RX_DEMOD]) * `RSQ_RX_STEP_US * CYC_PER_US;
    n_lead  = int'(tim[`RSQ_F_AMP_LEAD]) * CYC_PER_US;
    if (int'(tim[`RSQ_F_SW_LEAD]) > int'(tim[`RSQ_F_AMP_LEAD]))
      n_lead = int'(tim[`RSQ_F_SW_LEAD]) * CYC_PER_US;
    n_sw  = int'(tim[`RSQ_F_END_SW]) * CYC_PER_US;
    n_amp = int'(tim[`RSQ_F_END_AMP]) * CYC_PER_US;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_idle_steady;
    !seq_busy [*4];
  endsequence
  sequence s_read;
    cfg_rd_en ##1 cfg_rvalid;
  endsequence
  property p_after(ev, int c, int n);
    ev |-> (c + 2 >= n) && (c <= n + 3);
  endproperty

  a_read_answer: assert property (cfg_rd_en |-> s_read)
    else $error("read not answered in the next cycle");
  a_no_stray_valid: assert property (cfg_rvalid |-> $past(cfg_rd_en))
    else $error("read valid without a read");
  a_idle_override: assert property (s_idle_steady |-> ctrl == $past(expw))
    else $error("idle controls differ from masked value");
  a_mixer_pair: assert property (upmixer_powerdown == (amp_neg_powerdown && amp_pos_powerdown))
    else $error("mixer powerdown not the and of both amp paths");
  a_demod_in_chain: assert property (demod_agc_enable |-> rx_chain_enable)
    else $error("demodulator on without rx chain");
  a_chain_after_cal: assert property (p_after($rose(rx_chain_enable), cnt, CAL_CYCLES))
    else $error("rx chain enabled off the calibration time");
  a_demod_delay: assert property (p_after($rose(demod_agc_enable), on_cnt, n_demod))
    else $error("demodulator enable off its delay");
  a_tx_lead_time: assert property (p_after($rose(tx_enable), cnt, n_lead))
    else $error("tx enable off the lead time");
  a_switch_tail: assert property (p_after($fell(output_switch_bias_ctrl) && $past(seq_busy, 3),
                                          cnt, n_sw))
    else $error("switch off at wrong time after last chip");
  a_mod_tail: assert property (p_after($fell(modulator_enable), cnt, n_amp))
    else $error("modulator off at wrong time after last chip");
endmodule

bind rsq_seq_regs rsq_seq_regs_props #(.CAL_CYCLES(CAL_CYCLES), .CYC_PER_US(CYC_PER_US))
  u_props (.*);

// File: rsq_afe_model.sv
// Purpose: analog front end as seen from the overridden control lines
// Assumes: controls are settled levels between clock edges
// Notes:   gathers the sixteen controls into one word, bit order of the masks
module rsq_afe_model (
  input  wire logic vga_peak_reset_n, global_bias_powerdown, output_switch_bias_ctrl,
  input  wire logic buffer_path_select, prescaler_powerdown, amp_neg_powerdown,
  input  wire logic amp_pos_powerdown, tx_converter_powerdown, crystal_osc_powerdown,
  input  wire logic filter_cal_osc_powerdown, charge_pump_powerdown, synth_powerdown,
  input  wire logic rx_converter_powerdown, gain_amp_powerdown, rx_filter_powerdown,
  input  wire logic front_end_powerdown,
  output logic [15:0] afe_word
);
  timeunit 1ns;
  timeprecision 1ps;
  assign afe_word = {vga_peak_reset_n, global_bias_powerdown, output_switch_bias_ctrl,
                     buffer_path_select, prescaler_powerdown, amp_neg_powerdown,
                     amp_pos_powerdown, tx_converter_powerdown, crystal_osc_powerdown,
                     filter_cal_osc_powerdown, charge_pump_powerdown, synth_powerdown,
                     rx_converter_powerdown, gain_amp_powerdown, rx_filter_powerdown,
                     front_end_powerdown};
endmodule

// File: tb_radio_sequencing_override_regs.sv
// Purpose: self-checking bench of the sequencing registers and overrides
// Assumes: short calibration and microsecond counts set below
// Notes:   masks are changed only while the sequencer is idle
`include "rsq_consts.svh"
module tb_radio_sequencing_override_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 20, CPU = 4;
  typedef struct {logic [15:0] am; logic [15:0] om; logic [15:0] ctrl;} rsq_row_t;
  logic [5:0]  cfg_addr = 6'h00;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, afe_word, tw;
  logic clk = 1'b0, resetn = 1'b0, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, cfg_rvalid;
  logic rx_request = 1'b0, tx_request = 1'b0, tx_last_chip = 1'b0, seq_busy, front_end_powerdown;
  logic rx_chain_enable, demod_agc_enable, tx_enable, modulator_enable, upmixer_powerdown;
  logic vga_peak_reset_n, global_bias_powerdown, output_switch_bias_ctrl, buffer_path_select;
  logic prescaler_powerdown, amp_neg_powerdown, amp_pos_powerdown, tx_converter_powerdown;
  logic crystal_osc_powerdown, filter_cal_osc_powerdown, charge_pump_powerdown;
  logic synth_powerdown, rx_converter_powerdown, gain_amp_powerdown, rx_filter_powerdown;
  int n_mismatch = 0, n_checks = 0, cyc = 0, n;
  rsq_row_t rows [12] = '{
    '{16'hFFFE, 16'h0000, 16'h4F7E}, '{16'hFFFF, 16'h0001, 16'h4F7F},
    '{16'hFFC0, 16'h0000, 16'h4F40}, '{16'hFFFF, 16'h8000, 16'hCF7F},
    '{16'hBFFF, 16'h0000, 16'h0F7F}, '{16'hFFFF, 16'h2000, 16'h6F7F},
    '{16'hFFFF, 16'h1000, 16'h5F7F}, '{16'hF9FF, 16'h0000, 16'h497F},
    '{16'hFBFF, 16'h0000, 16'h4B7F}, '{16'hF6BF, 16'h0000, 16'h463F},
    '{16'h0000, 16'hFFFF, 16'hFFFF}, '{16'hFFFF, 16'h0000, 16'h4F7F}};

  rsq_seq_regs #(.CAL_CYCLES(CAL), .CYC_PER_US(CPU)) DUT (.*);
  rsq_afe_model afe (.*);

  always #2.5 clk = ~clk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hung wait ends the run here rather than stalling the simulator
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_in(input string what, input int k, input int lo, input int hi);
    n_checks++;
    if (k < lo || k > hi)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, k);
    end
  endtask
  // strobes drop with a spare cycle so no edge sees two assignments
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr_en <= 1'b1;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    cfg_addr <= a;
    cfg_rd_en <= 1'b1;
    @(posedge clk);
    cfg_rd_en <= 1'b0;
    #1;
    chk("read valid", 16'h0001, {15'h0000, cfg_rvalid});
    chk(what, exp, cfg_rdata);
    @(posedge clk);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, output int k);
    k = 0;
    while (k < 2000)
    begin
      @(posedge clk);
      #1;
      k++;
      if (s === v)
        break;
    end
  endtask

  initial
  begin
    tw = {3'd1, 3'd2, 4'd5, 3'd3, 3'd1};
    @(posedge clk);
    #1;
    chk("controls in reset", `RSQ_IDLE_CTRL, afe_word);
    @(posedge clk);
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`RSQ_OFF_TIMING, `RSQ_TIMING_RST, "timing reset");
    rd(`RSQ_OFF_AND_MASK, `RSQ_AND_MASK_RST, "and mask reset");
    rd(`RSQ_OFF_OR_MASK, `RSQ_OR_MASK_RST, "or mask reset");
    wr(6'h23, 16'h1234);
    rd(6'h23, 16'h0000, "unmapped read");
    foreach (rows[i])
    begin
      wr(`RSQ_OFF_AND_MASK, rows[i].am);
      wr(`RSQ_OFF_OR_MASK, rows[i].om);
      rd(`RSQ_OFF_AND_MASK, rows[i].am, "and mask readback");
      rd(`RSQ_OFF_OR_MASK, rows[i].om, "or mask readback");
      #1;
      chk("controls", rows[i].ctrl, afe_word);
      chk("mixer pd", {15'h0000, rows[i].ctrl[10] & rows[i].ctrl[9]},
          {15'h0000, upmixer_powerdown});
      @(posedge clk);
    end
    wr(`RSQ_OFF_TIMING, tw);
    rd(`RSQ_OFF_TIMING, tw, "timing readback");
    tx_request <= 1'b1;
    wait_lvl(amp_pos_powerdown, 1'b0, n);
    chk_in("amp on after request", n, 1, 3);
    wait_lvl(output_switch_bias_ctrl, 1'b1, n);
    chk_in("switch after amp", n, (5 - 2) * CPU - 2, (5 - 2) * CPU + 2);
    chk("path select", 16'h0001, {15'h0000, buffer_path_select});
    wait_lvl(tx_enable, 1'b1, n);
    chk_in("tx after switch", n, 2 * CPU - 1, 2 * CPU + 2);
    chk("amp neg on", 16'h0000, {15'h0000, amp_neg_powerdown});
    @(posedge clk);
    tx_last_chip <= 1'b1;
    tx_request <= 1'b0;
    @(posedge clk);
    tx_last_chip <= 1'b0;
    wait_lvl(modulator_enable, 1'b0, n);
    chk_in("modulator off", n, CPU - 1, CPU + 3);
    wait_lvl(amp_pos_powerdown, 1'b1, n);
    chk_in("amp off with modulator", n, 0, 2);
    wait_lvl(output_switch_bias_ctrl, 1'b0, n);
    chk_in("switch off", n, 2 * CPU - 3, 2 * CPU + 3);
    wait_lvl(seq_busy, 1'b0, n);
    @(posedge clk);
    rx_request <= 1'b1;
    wait_lvl(rx_chain_enable, 1'b1, n);
    chk_in("rx chain after cal", n, CAL, CAL + 4);
    wait_lvl(demod_agc_enable, 1'b1, n);
    chk_in("demod delay", n, 5 * CPU - 1, 5 * CPU + 3);
    @(posedge clk);
    tx_request <= 1'b1;
    wait_lvl(tx_enable, 1'b1, n);
    chk_in("tx wins over rx on", n, 5 * CPU, 5 * CPU + 4);
    chk("rx chain off in tx", 16'h0000, {15'h0000, rx_chain_enable});
    @(posedge clk);
    resetn <= 1'b0;
    rx_request <= 1'b0;
    #1;
    chk("busy in reset", 16'h0000, {15'h0000, seq_busy});
    @(posedge clk);
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`RSQ_OFF_TIMING, `RSQ_TIMING_RST, "timing after reset");
    end_sim();
  end
endmodule
